/* File: fflag_cfg.svh */
// Purpose: Constants for the sticky fault-flag register bank
// Assumes: 25 MHz system clock
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef FFLAG_CFG_SVH
`define FFLAG_CFG_SVH

// Register port widths
`define FF_ADDR_W        6
`define FF_DATA_W        16

// Register addresses
`define FF_ADDR_FLAGS    6'h06
`define FF_ADDR_ENABLE   6'h07

// Reset values
`define FF_FLAGS_RESET   16'h0000
`define FF_ENABLE_RESET  16'h0040

// Bits implemented in this bank; others read as zero
`define FF_LIVE_MASK     16'h01ff
`define FF_LIVE_W        9

// Flag positions
`define FF_BIT_REF       8
`define FF_BIT_CONV      7
`define FF_BIT_IGNORE    6
`define FF_BIT_FRAME     5
`define FF_BIT_RD_ADDR   4
`define FF_BIT_WR_ADDR   3
`define FF_BIT_LINK_CRC  2
`define FF_BIT_REGMAP    1
`define FF_BIT_ROM       0

// Serial frames must hold whole bytes of clock edges
`define FF_FRAME_UNIT    8
`define FF_FRAME_CNT_W   3

// Integrity checksum
`define FF_CRC_POLY      8'h07
`define FF_CRC_INIT      8'hff

// Register-map check period
`define FF_SYS_CLK_HZ    25000000
`define FF_MM_PERIOD_US  1000
`define FF_MM_PERIOD_CYC ((`FF_MM_PERIOD_US) * ((`FF_SYS_CLK_HZ) / 1000000))

`endif

/* File: fflag_pkg.sv */
// Purpose: Types shared by the fault-flag register bank
// Assumes: Nothing beyond the configuration header
// Notes:   State codes are one-hot
package fflag_pkg;

    // Periodic register-map check
    typedef enum logic [1:0] {
        FF_MM_IDLE = 2'b01,
        FF_MM_RUN  = 2'b10
    } fflag_mm_state_t;

    // Power-up ROM check
    typedef enum logic [2:0] {
        FF_ROM_LOAD  = 3'b001,
        FF_ROM_WAIT  = 3'b010,
        FF_ROM_READY = 3'b100
    } fflag_rom_state_t;

endpackage : fflag_pkg

/* File: fflag_crc.sv */
// Purpose: Serial CRC-8 over an image of 16-bit words, one word a clock
// Assumes: Image held stable while busy
// Notes:   Done pulses one cycle after the last word, result in crc_q
`include "fflag_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module fflag_crc #(
    parameter int WORDS = 8
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // Control
    input  wire logic                  start,
    input  wire logic [WORDS*16-1:0]   image,
    // Result
    output logic                       busy_q,
    output logic                       done_q,
    output logic [7:0]                 crc_q
);

    localparam int IW = (WORDS > 1) ? $clog2(WORDS) : 1;

    logic [IW-1:0] idx_q;   // Word being folded in

    // One word, most significant bit first
    function automatic logic [7:0] crc8_word(input logic [7:0] c, input logic [15:0] w);
        logic [7:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            r = (r[7] ^ w[i]) ? ({r[6:0], 1'b0} ^ `FF_CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction : crc8_word

    // Walk the image; a start while busy is ignored
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            crc_q  <= `FF_CRC_INIT;
            idx_q  <= '0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                busy_q <= 1'b1;
                idx_q  <= '0;
                crc_q  <= `FF_CRC_INIT;
            end else if (busy_q) begin
                crc_q <= crc8_word(crc_q, image[idx_q*16 +: 16]);
                if (idx_q == IW'(WORDS - 1)) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    idx_q <= idx_q + 1'b1;
                end
            end
        end
    end

endmodule : fflag_crc
`default_nettype wire

/* File: fflag_top.sv */
// Purpose: Sticky fault-flag register with its error-enable register
// Assumes: Condition inputs synchronous to sys_clk; register port is the
//          decoded serial access (one request per cycle)
// Notes:   Flags are write-one-to-clear; a set in the clear cycle wins
//
// Contract
// [R1] Reference below threshold sets flag 8
// [R2] Clamp, calibration or saturation sets flag 7
// [R3] Access while ignored sets flag 6
// [R4] Frame edge count not multiple of eight
// [R5] Read of invalid address sets flag 4
// [R6] Write to invalid address sets flag 3
// [R7] Link checksum mismatch sets flag 2
// [R8] Periodic register-map CRC while enabled
// [R9] Map changed without write sets flag 1
// [R10] Power-up ROM CRC mismatch sets flag 0
// [R11] Flag asserts only while enabled
// [R12] Write one clears, zero keeps, read returns
// [R13] Flags at 0x06, zero after reset
// [R14] Enable bit one enables, zero disables
// [R15] Flags stay set until cleared
`include "fflag_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module fflag_top
    import fflag_pkg::*;
#(
    parameter int                     MM_PERIOD_CYC = `FF_MM_PERIOD_CYC,
    parameter int                     MAP_WORDS     = 8,
    parameter int                     ROM_WORDS     = 8,
    parameter logic [`FF_ADDR_W-1:0]  LAST_ADDR     = 6'h1f
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // Register port
    input  wire logic [`FF_ADDR_W-1:0]    reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [`FF_DATA_W-1:0]    reg_wdata,
    output logic      [`FF_DATA_W-1:0]    reg_rdata_q,
    output logic                          reg_rvalid_q,
    // Conversion and reference conditions
    input  wire logic                     ref_below_thresh,
    input  wire logic                     adc_clamp_pos,
    input  wire logic                     adc_clamp_neg,
    input  wire logic                     cal_out_of_range,
    input  wire logic                     mod_saturated,
    // Serial link conditions
    input  wire logic                     ignore_access,
    input  wire logic                     frame_active,
    input  wire logic                     frame_sclk_edge,
    input  wire logic                     frame_crc_check,
    input  wire logic [7:0]               frame_crc_rx,
    input  wire logic [7:0]               frame_crc_calc,
    // Integrity images
    input  wire logic [MAP_WORDS*16-1:0]  regmap_image,
    input  wire logic [ROM_WORDS*16-1:0]  rom_image,
    input  wire logic [7:0]               rom_crc_ref,
    // Status
    output logic                          accesses_ignored_q
);

    // Register state
    logic [`FF_DATA_W-1:0]       flags_q;       // Sticky fault flags
    logic [`FF_DATA_W-1:0]       enable_q;      // Per-flag enables
    // Derived request and event terms
    logic                        ignoring;      // Accesses dropped now
    logic                        serial_access; // Any request this cycle
    logic                        wr_ok;         // Write accepted
    logic                        rd_ok;         // Read accepted
    logic [`FF_DATA_W-1:0]       clr;           // Write-one clear mask
    logic [`FF_DATA_W-1:0]       set_vec;       // Raw events
    logic [`FF_DATA_W-1:0]       gated;         // Events past enables
    logic [`FF_DATA_W-1:0]       clr_only;      // Clears with no new set
    // Frame edge counting
    logic                        frame_active_q;
    logic [`FF_FRAME_CNT_W-1:0]  edge_cnt_q;    // Edges modulo eight
    logic                        frame_bad;
    // Register-map check
    fflag_mm_state_t             mm_state_q;
    logic [31:0]                 mm_cnt_q;
    logic                        mm_start;
    logic                        mm_busy;
    logic                        mm_done;
    logic [7:0]                  mm_crc;
    logic [7:0]                  mm_ref_q;      // Map CRC known good
    logic                        mm_ref_valid_q;
    logic                        mm_dirty_q;    // Write landed mid-pass
    logic                        mm_bad;
    // ROM check
    fflag_rom_state_t            rom_state_q;
    logic                        rom_done;
    logic [7:0]                  rom_crc;
    logic                        rom_bad;
    logic                        rom_pend_q;    // Mismatch awaiting its enable

    // Locations that exist in the whole register map
    function automatic logic addr_valid(input logic [`FF_ADDR_W-1:0] a);
        return a <= LAST_ADDR;
    endfunction : addr_valid

    // Request decode; ROM download blocks the port
    always_comb begin
        ignoring      = (rom_state_q != FF_ROM_READY) || ignore_access;
        serial_access = reg_wr || reg_rd;
        wr_ok         = reg_wr && !ignoring && addr_valid(reg_addr);
        rd_ok         = reg_rd && !ignoring && addr_valid(reg_addr);
        clr           = (wr_ok && reg_addr == `FF_ADDR_FLAGS) ? reg_wdata : '0;
    end

    // Event sources, one per flag
    always_comb begin
        set_vec                   = '0;
        set_vec[`FF_BIT_REF]      = ref_below_thresh; // R1
        set_vec[`FF_BIT_CONV]     = adc_clamp_pos || adc_clamp_neg
                                    || cal_out_of_range || mod_saturated; // R2
        set_vec[`FF_BIT_IGNORE]   = serial_access && ignoring; // R3
        set_vec[`FF_BIT_FRAME]    = frame_bad; // R4
        set_vec[`FF_BIT_RD_ADDR]  = reg_rd && !ignoring && !addr_valid(reg_addr); // R5
        set_vec[`FF_BIT_WR_ADDR]  = reg_wr && !ignoring && !addr_valid(reg_addr); // R6
        set_vec[`FF_BIT_LINK_CRC] = frame_crc_check && (frame_crc_rx != frame_crc_calc); // R7
        set_vec[`FF_BIT_REGMAP]   = mm_bad; // R9
        set_vec[`FF_BIT_ROM]      = rom_bad || rom_pend_q; // R10
        gated    = set_vec & enable_q & `FF_LIVE_MASK; // R11 R14
        clr_only = clr & ~gated;
    end

    // Sticky flags: new events win over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flags_q <= `FF_FLAGS_RESET; // R13
        end else begin
            flags_q <= ((flags_q & ~clr) | gated) & `FF_LIVE_MASK; // R12 R15
        end
    end

    // Enable register; bits outside the live set are reserved
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            enable_q <= `FF_ENABLE_RESET;
        end else if (wr_ok && reg_addr == `FF_ADDR_ENABLE) begin
            enable_q <= reg_wdata & `FF_LIVE_MASK; // R14
        end
    end

    // Read port; unhandled valid addresses and bad ones read zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata_q  <= '0;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd && !ignoring;
            case (reg_addr)
                `FF_ADDR_FLAGS:  reg_rdata_q <= flags_q; // R12
                `FF_ADDR_ENABLE: reg_rdata_q <= enable_q;
                default:         reg_rdata_q <= '0;
            endcase
        end
    end

    // Frame edges counted modulo eight, checked when chip select drops
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            frame_active_q <= 1'b0;
            edge_cnt_q     <= '0;
        end else begin
            frame_active_q <= frame_active;
            if (!frame_active) begin
                edge_cnt_q <= '0;
            end else if (frame_sclk_edge) begin
                edge_cnt_q <= edge_cnt_q + 1'b1;
            end
        end
    end

    assign frame_bad = frame_active_q && !frame_active && (edge_cnt_q != '0); // R4

    // Periodic map check runs only while its flag is enabled
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mm_state_q <= FF_MM_IDLE;
            mm_cnt_q   <= '0;
        end else if (!enable_q[`FF_BIT_REGMAP]) begin
            mm_state_q <= FF_MM_IDLE;
            mm_cnt_q   <= '0;
        end else begin
            case (mm_state_q)
                FF_MM_IDLE: begin
                    if (mm_start) begin
                        mm_state_q <= FF_MM_RUN; // R8
                        mm_cnt_q   <= '0;
                    end else begin
                        mm_cnt_q <= mm_cnt_q + 32'h1;
                    end
                end
                FF_MM_RUN: begin
                    if (mm_done) begin
                        mm_state_q <= FF_MM_IDLE;
                    end
                end
                default: mm_state_q <= FF_MM_IDLE;
            endcase
        end
    end

    assign mm_start = enable_q[`FF_BIT_REGMAP] && (mm_state_q == FF_MM_IDLE)
                      && (mm_cnt_q == 32'(MM_PERIOD_CYC - 1)); // R8

    // Reference CRC: a legitimate write makes the next clean pass the new
    // reference, so only changes without writes are reported
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mm_ref_q       <= `FF_CRC_INIT;
            mm_ref_valid_q <= 1'b0;
            mm_dirty_q     <= 1'b0;
        end else if (!enable_q[`FF_BIT_REGMAP] || wr_ok) begin
            mm_ref_valid_q <= 1'b0;
            mm_dirty_q     <= mm_busy && wr_ok;
        end else if (mm_done) begin
            mm_dirty_q <= 1'b0;
            if (!mm_ref_valid_q && !mm_dirty_q) begin
                mm_ref_q       <= mm_crc;
                mm_ref_valid_q <= 1'b1;
            end
        end
    end

    assign mm_bad = mm_done && mm_ref_valid_q && !wr_ok && (mm_crc != mm_ref_q); // R9

    fflag_crc #(
        .WORDS   (MAP_WORDS)
    ) u_map_crc (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (mm_start),
        .image   (regmap_image),
        .busy_q  (mm_busy),
        .done_q  (mm_done),
        .crc_q   (mm_crc)
    );

    // ROM check once after reset; the port stays blocked until done
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rom_state_q <= FF_ROM_LOAD;
        end else begin
            case (rom_state_q)
                FF_ROM_LOAD:  rom_state_q <= FF_ROM_WAIT;
                FF_ROM_WAIT:  if (rom_done) rom_state_q <= FF_ROM_READY;
                FF_ROM_READY: rom_state_q <= FF_ROM_READY;
                default:      rom_state_q <= FF_ROM_LOAD;
            endcase
        end
    end

    assign rom_bad = rom_done && (rom_state_q == FF_ROM_WAIT) && (rom_crc != rom_crc_ref); // R10

    // The check ends before the host can enable flag 0, so a mismatch is
    // held until that enable is set instead of being lost
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rom_pend_q <= 1'b0;
        end else if (rom_bad) begin
            rom_pend_q <= 1'b1; // R10
        end else if (enable_q[`FF_BIT_ROM]) begin
            rom_pend_q <= 1'b0;
        end
    end

    fflag_crc #(
        .WORDS   (ROM_WORDS)
    ) u_rom_crc (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (rom_state_q == FF_ROM_LOAD),
        .image   (rom_image),
        .busy_q  (),
        .done_q  (rom_done),
        .crc_q   (rom_crc)
    );

    // Ignore status for the serial front end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            accesses_ignored_q <= 1'b1;
        end else begin
            accesses_ignored_q <= ignoring;
        end
    end

    // Checks
    default clocking ff_cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence frame_close_s;
        frame_active ##1 !frame_active;
    endsequence

    sequence ignored_req_s;
        serial_access && ignoring && enable_q[`FF_BIT_IGNORE];
    endsequence

    reset_clear_a: assert property ($fell(rst) |-> (flags_q == '0) && !reg_rvalid_q) // R13
        else $error("flags not zero after reset");
    set_wins_a: assert property ((|gated) |=> ((flags_q & $past(gated)) == $past(gated))) // R15
        else $error("enabled event did not set its flag");
    w1c_clear_a: assert property ((|clr_only) |=> ((flags_q & $past(clr_only)) == '0)) // R12
        else $error("write one did not clear flag");
    sticky_hold_a: assert property ((($past(flags_q) & ~$past(clr)) & ~flags_q) == '0) // R15
        else $error("flag dropped without a clear");
    enable_gate_a: assert property (((flags_q & ~$past(flags_q)) & ~$past(enable_q)) == '0) // R11
        else $error("disabled flag was set");
    frame_count_a: assert property (frame_close_s ##0 (edge_cnt_q != '0 && enable_q[5])
                                    |=> flags_q[`FF_BIT_FRAME]) // R4
        else $error("short frame not flagged");
    ignore_flag_a: assert property (ignored_req_s |=> flags_q[`FF_BIT_IGNORE] && !reg_rvalid_q) // R3
        else $error("ignored access not flagged");
    bad_read_a: assert property (reg_rd && !ignoring && !addr_valid(reg_addr) && enable_q[4]
                                 |=> flags_q[`FF_BIT_RD_ADDR] && reg_rdata_q == '0) // R5
        else $error("invalid read not flagged");
    bad_write_a: assert property (reg_wr && !ignoring && !addr_valid(reg_addr) && enable_q[3]
                                  |=> flags_q[`FF_BIT_WR_ADDR]) // R6
        else $error("invalid write not flagged");
    link_crc_a: assert property (frame_crc_check && frame_crc_rx != frame_crc_calc
                                 && enable_q[2] |=> flags_q[`FF_BIT_LINK_CRC]) // R7
        else $error("link checksum error not flagged");
    mm_period_a: assert property (mm_cnt_q < 32'(MM_PERIOD_CYC)) // R8
        else $error("map check period overran");
    rom_check_a: assert property (rom_pend_q && enable_q[0] |=> flags_q[`FF_BIT_ROM]) // R10
        else $error("ROM mismatch not flagged");

endmodule : fflag_top
`default_nettype wire

/* File: fflag_host_model.sv */
// Purpose: Host side of the register port, one request at a time
// Assumes: Requests start at a falling edge of sys_clk
// Notes:   Idle address and data show the inverse of the last value
`include "fflag_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module fflag_host_model (
    // Clock and device answers
    input  wire logic                  sys_clk,
    input  wire logic [`FF_DATA_W-1:0] reg_rdata_q,
    input  wire logic                  reg_rvalid_q,
    input  wire logic                  accesses_ignored_q,
    // Request lines
    output logic      [`FF_ADDR_W-1:0] reg_addr,
    output logic                       reg_wr,
    output logic                       reg_rd,
    output logic      [`FF_DATA_W-1:0] reg_wdata
);
    // Quiet port at time zero
    initial begin
        reg_addr  = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = '0;
    end

    // One request; skipping the ignore wait lets a refusal be provoked
    task automatic access(input logic wr, input logic [`FF_ADDR_W-1:0] a,
                          input logic [`FF_DATA_W-1:0] d, input logic wait_ok,
                          output logic [`FF_DATA_W-1:0] q, output logic got);
        int n;
        n = 0;
        @(negedge sys_clk);
        // Bounded, so a stuck ignore flag cannot hang the host
        while (wait_ok && accesses_ignored_q !== 1'b0 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = wr;
        reg_rd    = ~wr;
        @(negedge sys_clk);
        // Answer is settled one edge after the request edge
        got       = reg_rvalid_q;
        q         = reg_rdata_q;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : access
endmodule : fflag_host_model
`default_nettype wire

/* File: fault_flag_register_tb_top.sv */
// Purpose: Self-checking bench for the fault-flag register bank
// Assumes: Inputs change at falling edges only
// Notes:   Map-check period shortened to 40 cycles to keep the run short
`include "fflag_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module fault_flag_register_tb_top;
    localparam int MM_CYC = 40;          // Shortened check period
    logic          sys_clk;              // System clock
    logic          rst;                  // Synchronous reset
    logic [5:0]    reg_addr;             // Host request lines
    logic          reg_wr;
    logic          reg_rd;
    logic [15:0]   reg_wdata;
    logic [15:0]   reg_rdata_q;          // Device answer
    logic          reg_rvalid_q;
    logic [4:0]    cond;                 // Reference and conversion faults
    logic          ignore_access;        // Link condition inputs
    logic          frame_active;
    logic          frame_sclk_edge;
    logic          frame_crc_check;
    logic [7:0]    frame_crc_rx;
    logic [7:0]    frame_crc_calc;
    logic [127:0]  regmap_image;         // Map contents seen by the check
    logic [15:0]   rom_image;            // One ROM word, checksum 8'h26
    logic [7:0]    rom_crc_ref;
    logic          accesses_ignored_q;
    int            err_count;
    int            tests_run;

    fflag_top #(.MM_PERIOD_CYC(MM_CYC), .ROM_WORDS(1)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q), .ref_below_thresh(cond[0]),
        .adc_clamp_pos(cond[1]), .adc_clamp_neg(cond[2]),
        .cal_out_of_range(cond[3]), .mod_saturated(cond[4]),
        .ignore_access(ignore_access), .frame_active(frame_active),
        .frame_sclk_edge(frame_sclk_edge), .frame_crc_check(frame_crc_check),
        .frame_crc_rx(frame_crc_rx), .frame_crc_calc(frame_crc_calc),
        .regmap_image(regmap_image), .rom_image(rom_image),
        .rom_crc_ref(rom_crc_ref), .accesses_ignored_q(accesses_ignored_q));

    fflag_host_model u_host (
        .sys_clk(sys_clk), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .accesses_ignored_q(accesses_ignored_q), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    // Compare and count
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Read must answer; data compared to expectation
    task automatic rd(input logic [5:0] a, input logic [15:0] exp, input string what);
        logic [15:0] q;
        logic        g;
        u_host.access(1'b0, a, 16'h0000, 1'b1, q, g);
        chk({what, " answer"}, 16'h0001, {15'h0000, g});
        chk(what, exp, q);
    endtask : rd

    // Write, no answer expected
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic        g;
        u_host.access(1'b1, a, d, 1'b1, q, g);
    endtask : wr

    // Reset state; ROM mismatch waits while its enable is off
    task automatic t_reset;
        chk("ignored after reset", 16'h0001, {15'h0000, accesses_ignored_q});
        rd(`FF_ADDR_FLAGS, 16'h0000, "flags at reset");
        rd(`FF_ADDR_ENABLE, 16'h0040, "enable at reset");
        $display("test reset done");
    endtask : t_reset

    // Refused access, then write-zero keeps and write-one clears
    task automatic t_ignore;
        logic [15:0] q;
        logic        g;
        ignore_access = 1'b1;
        u_host.access(1'b0, `FF_ADDR_ENABLE, 16'h0000, 1'b0, q, g);
        chk("answer while ignored", 16'h0000, {15'h0000, g});
        ignore_access = 1'b0;
        rd(`FF_ADDR_FLAGS, 16'h0040, "ignore flag");
        wr(`FF_ADDR_FLAGS, 16'h0000);
        rd(`FF_ADDR_FLAGS, 16'h0040, "write zero keeps");
        wr(`FF_ADDR_FLAGS, 16'h0040);
        rd(`FF_ADDR_FLAGS, 16'h0000, "write one clears");
        $display("test ignore done");
    endtask : t_ignore

    // Each fault for one cycle; flag must outlive it; none when disabled
    task automatic t_cond;
        wr(`FF_ADDR_ENABLE, 16'h01ff);
        for (int k = 0; k < 5; k++) begin
            @(negedge sys_clk);
            cond = 5'h01 << k;
            @(negedge sys_clk);
            cond = 5'h00;
            repeat (3) @(negedge sys_clk);
            rd(`FF_ADDR_FLAGS, (k == 0) ? 16'h0101 : 16'h0080, "fault flag");
            wr(`FF_ADDR_FLAGS, 16'h01ff);
        end
        wr(`FF_ADDR_ENABLE, 16'h0000);
        @(negedge sys_clk);
        cond = 5'h1f;
        @(negedge sys_clk);
        cond = 5'h00;
        rd(`FF_ADDR_FLAGS, 16'h0000, "disabled faults");
        $display("test conditions done");
    endtask : t_cond

    // Checksum compare pulse
    task automatic crc_case(input logic [7:0] calc, input logic [15:0] exp);
        @(negedge sys_clk);
        frame_crc_rx    = 8'h5a;
        frame_crc_calc  = calc;
        frame_crc_check = 1'b1;
        @(negedge sys_clk);
        frame_crc_check = 1'b0;
        rd(`FF_ADDR_FLAGS, exp, "checksum flag");
    endtask : crc_case

    // Frame with n clock edges
    task automatic frame_case(input int n, input logic [15:0] exp);
        @(negedge sys_clk);
        frame_active = 1'b1;
        for (int i = 0; i < n; i++) begin
            frame_sclk_edge = 1'b1;
            @(negedge sys_clk);
            frame_sclk_edge = 1'b0;
            @(negedge sys_clk);
        end
        frame_active = 1'b0;
        repeat (2) @(negedge sys_clk);
        rd(`FF_ADDR_FLAGS, exp, "frame flag");
    endtask : frame_case

    // Link faults: bad addresses, checksum, frame length
    task automatic t_link;
        logic [15:0] q;
        logic        g;
        wr(`FF_ADDR_ENABLE, 16'h01ff);
        u_host.access(1'b0, 6'h20, 16'h0000, 1'b1, q, g);
        chk("invalid read data", 16'h0000, q);
        u_host.access(1'b1, 6'h3f, 16'hffff, 1'b1, q, g);
        rd(`FF_ADDR_FLAGS, 16'h0018, "address flags");
        wr(`FF_ADDR_FLAGS, 16'h0018);
        crc_case(8'h5a, 16'h0000);
        crc_case(8'h5b, 16'h0004);
        wr(`FF_ADDR_FLAGS, 16'h0004);
        frame_case(16, 16'h0000);
        frame_case(7, 16'h0020);
        $display("test link done");
    endtask : t_link

    // Map check: quiet while stable, flag once contents change
    task automatic t_map;
        wr(`FF_ADDR_FLAGS, 16'h01ff);
        wr(`FF_ADDR_ENABLE, 16'h0002);
        repeat (3 * MM_CYC) @(negedge sys_clk);
        rd(`FF_ADDR_FLAGS, 16'h0000, "map unchanged");
        regmap_image[3] = ~regmap_image[3];
        cond = 5'h01;
        @(negedge sys_clk);
        cond = 5'h00;
        repeat (3 * MM_CYC) @(negedge sys_clk);
        rd(`FF_ADDR_FLAGS, 16'h0002, "map changed");
        $display("test map done");
    endtask : t_map

    // Mid-run reset with a matching ROM: flag 0 stays clear once enabled
    task automatic t_rom;
        rst         = 1'b1;
        rom_crc_ref = 8'h26;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        rd(`FF_ADDR_FLAGS, 16'h0000, "flags after reset");
        wr(`FF_ADDR_ENABLE, 16'h0001);
        rd(`FF_ADDR_FLAGS, 16'h0000, "ROM match");
        $display("test rom done");
    endtask : t_rom

    // Verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Main sequence
    initial begin
        err_count       = 0;
        tests_run       = 0;
        rst             = 1'b1;
        cond            = 5'h00;
        ignore_access   = 1'b0;
        frame_active    = 1'b0;
        frame_sclk_edge = 1'b0;
        frame_crc_check = 1'b0;
        frame_crc_rx    = 8'h00;
        frame_crc_calc  = 8'h00;
        regmap_image    = {8{16'ha5c3}};
        rom_image       = 16'h1234;
        rom_crc_ref     = 8'h00;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        t_reset;
        t_ignore;
        t_cond;
        t_link;
        t_map;
        t_rom;
        report_and_stop;
    end

    // Watchdog, well beyond the roughly 420 cycles the tests need
    initial begin
        #(5000 * 40);
        err_count++;
        $display("[FAIL] run time expected end seen hang");
        report_and_stop;
    end
endmodule : fault_flag_register_tb_top
`default_nettype wire
